// [verilog/chgctl_pkg.sv]
// chgctl_pkg: shared constants and types for the charger path control block
package chgctl_pkg;
  // ==========================================================
  // register indices (plain port, one word each)
  localparam logic [3:0] ADDR_INLIM = 4'h0;
  localparam logic [3:0] ADDR_CHGCFG = 4'h1;
  localparam logic [3:0] ADDR_CHGCUR = 4'h2;
  localparam logic [3:0] ADDR_PRETRM = 4'h3;
  localparam logic [3:0] ADDR_CHGVOLT = 4'h4;
  localparam logic [3:0] ADDR_TIMER = 4'h5;
  localparam logic [3:0] ADDR_MISC = 4'h7;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_FAULT = 4'h9;
  // ==========================================================
  // field positions
  localparam int CFG_LSB = 4;
  localparam int CFG_MSB = 5;
  localparam int BOOST_SEL_BIT = 0;
  localparam int MINSYS_LSB = 1;
  localparam int MINSYS_MSB = 3;
  localparam int FORCE_DET_BIT = 7;
  localparam int SWITCH_OFF_BIT = 5;
  localparam int RECHG_BIT = 0;
  localparam int LOWBAT_BIT = 1;
  localparam int SRC_LSB = 6;
  localparam int PHASE_LSB = 4;
  localparam int PGOOD_BIT = 2;
  localparam int PM_BIT = 3;
  localparam int MINREG_BIT = 0;
  localparam int BFAULT_BIT = 6;
  // ==========================================================
  // reset values
  localparam logic [7:0] INLIM_RST = 8'h30;
  localparam logic [7:0] CHGCFG_RST = 8'h1b;  // cfg 01, min sys 3.5 V
  localparam logic [7:0] CHGCUR_RST = 8'h60;  // 2.048 A
  localparam logic [7:0] PRETRM_RST = 8'h11;  // 256 mA / 256 mA
  localparam logic [7:0] CHGVOLT_RST = 8'hb2; // 4.208 V
  localparam logic [7:0] TIMER_RST = 8'h9a;   // eight-hour timer
  localparam logic [7:0] MISC_RST = 8'h4b;
  // ==========================================================
  // encodings
  localparam logic [1:0] CFG_DISABLE = 2'h0;
  localparam logic [1:0] CFG_CHARGE = 2'h1;
  localparam logic [1:0] CFG_BOOST = 2'h2;
  localparam logic [1:0] SRC_UNKNOWN = 2'h0;
  localparam logic [1:0] SRC_BOOST = 2'h3;
  localparam logic [1:0] PH_OFF = 2'h0;
  localparam logic [1:0] PH_PRE = 2'h1;
  localparam logic [1:0] PH_FAST = 2'h2;
  localparam logic [1:0] PH_DONE = 2'h3;
  localparam logic [2:0] EXTERNAL_LIMIT_PIN_100MA = 3'h0;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int BOOST_DLY_MS = 220;
  localparam int BOOST_DLY_CYC = BOOST_DLY_MS * 1000 * CLK_MHZ;
  localparam int INT_PULSE_CYC = 4;
  localparam int BLINK_CYC = 50000000;
  // ==========================================================
  // converter sequencing states
  typedef enum logic [2:0] {
    CHGCTL_IDLE = 3'b000,
    CHGCTL_DETECT = 3'b001,
    CHGCTL_BUCK = 3'b011,
    CHGCTL_BOOSTWAIT = 3'b010,
    CHGCTL_BOOST = 3'b110
  } chgctl_state_t;
endpackage : chgctl_pkg

// [verilog/chgctl_top.sv]
// chgctl_top: power path, boost and charge cycle control with register port
`timescale 1ns/1ps
// What this block does
// - force-detection bit reruns detection, then self-clears.
// - limit set: converter on; battery switch off if charging disabled.
// - system below 2.2 V forces 100 mA, else lower of register and pin.
// - light load: pulse-frequency mode if battery below minimum or charge off.
// - boost needs battery ok, input low, pin high, config 10, 220 ms wait.
// - boost: source field 11; select bit picks current limit.
// - boost fault sets fault bit and raises interrupt.
// - minimum system voltage field programmable, default 3.5 V.
// - battery low, disabled or done: system 150 mV above minimum.
// - minimum-regulation bit follows minimum system regulation.
// - input over current or under voltage reduces charge current.
// - zero charge current, system below battery: battery switch on.
// - power-management bit high while either loop active.
// - supplement ends once battery below depletion threshold.
// - reset: 4.208 V, 2.048 A, 256 mA pre/term, eight-hour timer.
// - config 01 at reset: full charge cycle with no host access.
// - charge needs running, config 01, enable low, no faults, switch allowed.
// - cycle ends: current below termination, voltage above recharge.
// - done battery below recharge threshold restarts charging.
// - status pin low charging, high done or disabled, blinks on thermistor or safety timer fault.
// - phase: 00 off, 01 precharge, 10 fast or constant voltage, 11 done.
// - charge completion raises interrupt.
// - qualified source sets power-good bit and raises interrupt.
module chgctl_top #(
  parameter int BOOST_DLY = chgctl_pkg::BOOST_DLY_CYC,
  parameter int BLINK_HALF = chgctl_pkg::BLINK_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // register port
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // analog comparators and pins
  input wire logic src_ok_in,
  input wire logic detect_done_in,
  input wire logic [1:0] detect_src_in,
  input wire logic [2:0] detect_lim_in,
  input wire logic [2:0] external_limit_pin_in,
  input wire logic sys_above_2v2_in,
  input wire logic light_load_in,
  input wire logic bat_below_minsys_in,
  input wire logic bat_above_lowbat_in,
  input wire logic vbus_below_sleep_in,
  input wire logic on_the_go_pin_in,
  input wire logic charge_en_n_in,
  input wire logic thermistor_fault_in,
  input wire logic safety_timer_fault_in,
  input wire logic boost_fault_in,
  input wire logic input_current_over_in,
  input wire logic input_voltage_under_in,
  input wire logic sys_below_bat_in,
  input wire logic bat_depleted_in,
  input wire logic bat_above_precharge_in,
  input wire logic chg_below_term_in,
  input wire logic bat_above_recharge_in,
  // power stage controls
  output logic high_side_switch_en_out,
  output logic low_side_switch_en_out,
  output logic battery_switch_on_out,
  output logic battery_switch_linear_out,
  output logic pfm_mode_out,
  output logic boost_mode_out,
  output logic boost_high_current_out,
  output logic [2:0] input_limit_out,
  output logic minsys_reg_out,
  output logic reduce_charge_out,
  output logic run_detect_out,
  // status pins
  output logic stat_out,
  output logic int_out
);
  logic [1:0] rst_sync_reg;
  logic rstn;
  chgctl_pkg::chgctl_state_t state_reg, state_next;
  logic [7:0] inlim_reg, cfg_reg, chgcur_reg, pretrm_reg, volt_reg, timer_reg, misc_reg;
  logic [7:0] rdata_reg;
  logic [31:0] boost_cnt_reg;
  logic [31:0] blink_cnt_reg;
  logic blink_reg;
  logic [1:0] phase_reg;
  logic [1:0] src_reg;
  logic pgood_reg, bfault_reg, supp_reg, charging_allowed;
  logic [2:0] int_cnt_reg;
  logic detect_done_ev, pgood_ev, bfault_ev, done_ev;
  logic boost_qual, chg_disabled, minsys_reg;

  function automatic logic [2:0] min3(input logic [2:0] a, input logic [2:0] b);
    min3 = (a < b) ? a : b;
  endfunction : min3

  // ==========================================================
  // reset release
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rstn = rst_sync_reg[1];

  // ==========================================================
  // registers
  assign detect_done_ev = (state_reg == chgctl_pkg::CHGCTL_DETECT) && detect_done_in;
  always_ff @(posedge clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      inlim_reg <= chgctl_pkg::INLIM_RST;
      cfg_reg <= chgctl_pkg::CHGCFG_RST;
      chgcur_reg <= chgctl_pkg::CHGCUR_RST;
      pretrm_reg <= chgctl_pkg::PRETRM_RST;
      volt_reg <= chgctl_pkg::CHGVOLT_RST;
      timer_reg <= chgctl_pkg::TIMER_RST;
      misc_reg <= chgctl_pkg::MISC_RST;
    end
    else
    begin
      if (wr_in)
      begin
        unique case (addr_in)
          chgctl_pkg::ADDR_INLIM: inlim_reg <= wdata_in;
          chgctl_pkg::ADDR_CHGCFG: cfg_reg <= wdata_in;
          chgctl_pkg::ADDR_CHGCUR: chgcur_reg <= wdata_in;
          chgctl_pkg::ADDR_PRETRM: pretrm_reg <= wdata_in;
          chgctl_pkg::ADDR_CHGVOLT: volt_reg <= wdata_in;
          chgctl_pkg::ADDR_TIMER: timer_reg <= wdata_in;
          chgctl_pkg::ADDR_MISC: misc_reg <= wdata_in;
          default: ;
        endcase
      end
      // self clear wins over a same-cycle write
      if (detect_done_ev)
        misc_reg[chgctl_pkg::FORCE_DET_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn)
  begin
    if (!rstn)
      rdata_reg <= 8'h00;
    else if (rd_in)
    begin
      unique case (addr_in)
        chgctl_pkg::ADDR_INLIM: rdata_reg <= inlim_reg;
        chgctl_pkg::ADDR_CHGCFG: rdata_reg <= cfg_reg;
        chgctl_pkg::ADDR_CHGCUR: rdata_reg <= chgcur_reg;
        chgctl_pkg::ADDR_PRETRM: rdata_reg <= pretrm_reg;
        chgctl_pkg::ADDR_CHGVOLT: rdata_reg <= volt_reg;
        chgctl_pkg::ADDR_TIMER: rdata_reg <= timer_reg;
        chgctl_pkg::ADDR_MISC: rdata_reg <= misc_reg;
        chgctl_pkg::ADDR_STATUS: rdata_reg <= {src_reg, phase_reg, reduce_charge_out,
                                               pgood_reg, 1'b0, minsys_reg_out};
        chgctl_pkg::ADDR_FAULT: rdata_reg <= {1'b0, bfault_reg, 6'h00};
        default: rdata_reg <= 8'h00;
      endcase
    end
    else
      rdata_reg <= 8'h00;
  end
  assign rdata_out = rdata_reg;

  // ==========================================================
  // converter sequencing
  assign boost_qual = bat_above_lowbat_in && vbus_below_sleep_in && on_the_go_pin_in
    && (cfg_reg[chgctl_pkg::CFG_MSB:chgctl_pkg::CFG_LSB] == chgctl_pkg::CFG_BOOST);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      chgctl_pkg::CHGCTL_IDLE:
        if (src_ok_in)
          state_next = chgctl_pkg::CHGCTL_DETECT;
        else if (boost_qual)
          state_next = chgctl_pkg::CHGCTL_BOOSTWAIT;
      chgctl_pkg::CHGCTL_DETECT:
        if (!src_ok_in)
          state_next = chgctl_pkg::CHGCTL_IDLE;
        else if (detect_done_in)
          state_next = chgctl_pkg::CHGCTL_BUCK;
      chgctl_pkg::CHGCTL_BUCK:
        if (!src_ok_in)
          state_next = chgctl_pkg::CHGCTL_IDLE;
        else if (misc_reg[chgctl_pkg::FORCE_DET_BIT])
          state_next = chgctl_pkg::CHGCTL_DETECT;
      chgctl_pkg::CHGCTL_BOOSTWAIT:
        if (!boost_qual)
          state_next = chgctl_pkg::CHGCTL_IDLE;
        else if (boost_cnt_reg >= 32'(BOOST_DLY - 1))
          state_next = chgctl_pkg::CHGCTL_BOOST;
      chgctl_pkg::CHGCTL_BOOST:
        if (!boost_qual || boost_fault_in)
          state_next = chgctl_pkg::CHGCTL_IDLE;
      default: state_next = chgctl_pkg::CHGCTL_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn)
  begin
    if (!rstn)
      state_reg <= chgctl_pkg::CHGCTL_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk_in or negedge rstn)
  begin
    if (!rstn)
      boost_cnt_reg <= 32'h0;
    else if (state_reg == chgctl_pkg::CHGCTL_BOOSTWAIT && boost_qual)
      boost_cnt_reg <= boost_cnt_reg + 32'h1;
    else
      boost_cnt_reg <= 32'h0;
  end

  // ==========================================================
  // source status and faults
  assign pgood_ev = src_ok_in && !pgood_reg;
  assign bfault_ev = boost_fault_in && (state_reg == chgctl_pkg::CHGCTL_BOOST);
  always_ff @(posedge clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      pgood_reg <= 1'b0;
      bfault_reg <= 1'b0;
      src_reg <= chgctl_pkg::SRC_UNKNOWN;
      input_limit_out <= chgctl_pkg::EXTERNAL_LIMIT_PIN_100MA;
    end
    else
    begin
      pgood_reg <= src_ok_in;
      if (bfault_ev)
        bfault_reg <= 1'b1;
      else if (rd_in && addr_in == chgctl_pkg::ADDR_FAULT)
        bfault_reg <= 1'b0;
      if (state_next == chgctl_pkg::CHGCTL_BOOST)
        src_reg <= chgctl_pkg::SRC_BOOST;
      else if (detect_done_ev)
        src_reg <= detect_src_in;
      else if (!src_ok_in)
        src_reg <= chgctl_pkg::SRC_UNKNOWN;
      if (!sys_above_2v2_in)
        input_limit_out <= chgctl_pkg::EXTERNAL_LIMIT_PIN_100MA;
      else
        input_limit_out <= min3(inlim_reg[2:0], external_limit_pin_in);
    end
  end
  assign run_detect_out = (state_reg == chgctl_pkg::CHGCTL_DETECT);

  // ==========================================================
  // charge cycle
  assign chg_disabled = cfg_reg[chgctl_pkg::CFG_MSB:chgctl_pkg::CFG_LSB] != chgctl_pkg::CFG_CHARGE
    || charge_en_n_in || misc_reg[chgctl_pkg::SWITCH_OFF_BIT];
  assign charging_allowed = (state_reg == chgctl_pkg::CHGCTL_BUCK) && !chg_disabled
    && !thermistor_fault_in && !safety_timer_fault_in;
  assign done_ev = (phase_reg == chgctl_pkg::PH_FAST) && charging_allowed && chg_below_term_in
    && bat_above_recharge_in && !reduce_charge_out;
  always_ff @(posedge clk_in or negedge rstn)
  begin
    if (!rstn)
      phase_reg <= chgctl_pkg::PH_OFF;
    else if (!charging_allowed)
    begin
      if (phase_reg != chgctl_pkg::PH_DONE || chg_disabled)
        phase_reg <= chgctl_pkg::PH_OFF;
    end
    else
    begin
      unique case (phase_reg)
        chgctl_pkg::PH_OFF, chgctl_pkg::PH_PRE:
          phase_reg <= bat_above_precharge_in ? chgctl_pkg::PH_FAST : chgctl_pkg::PH_PRE;
        chgctl_pkg::PH_FAST:
          if (done_ev)
            phase_reg <= chgctl_pkg::PH_DONE;
        chgctl_pkg::PH_DONE:
          if (!bat_above_recharge_in)
            phase_reg <= chgctl_pkg::PH_PRE;
      endcase
    end
  end

  // ==========================================================
  // power path
  assign minsys_reg = bat_below_minsys_in || chg_disabled || phase_reg == chgctl_pkg::PH_DONE;
  assign reduce_charge_out = input_current_over_in || input_voltage_under_in;
  always_ff @(posedge clk_in or negedge rstn)
  begin
    if (!rstn)
      supp_reg <= 1'b0;
    else if (bat_depleted_in || misc_reg[chgctl_pkg::SWITCH_OFF_BIT])
      supp_reg <= 1'b0;
    else if (sys_below_bat_in && (reduce_charge_out || phase_reg != chgctl_pkg::PH_FAST))
      supp_reg <= 1'b1;
    else if (!sys_below_bat_in)
      supp_reg <= 1'b0;
  end
  assign high_side_switch_en_out = (state_reg == chgctl_pkg::CHGCTL_BUCK)
    || (state_reg == chgctl_pkg::CHGCTL_BOOST);
  assign low_side_switch_en_out = high_side_switch_en_out;
  assign battery_switch_on_out = (charging_allowed && phase_reg != chgctl_pkg::PH_DONE)
    || supp_reg || (state_reg == chgctl_pkg::CHGCTL_BOOST);
  assign battery_switch_linear_out = bat_below_minsys_in && battery_switch_on_out;
  assign minsys_reg_out = minsys_reg && (state_reg == chgctl_pkg::CHGCTL_BUCK);
  assign pfm_mode_out = light_load_in && (bat_below_minsys_in || chg_disabled);
  assign boost_mode_out = (state_reg == chgctl_pkg::CHGCTL_BOOST);
  assign boost_high_current_out = cfg_reg[chgctl_pkg::BOOST_SEL_BIT];

  // ==========================================================
  // status pin and interrupt
  always_ff @(posedge clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= 1'b0;
    end
    else if (blink_cnt_reg >= 32'(BLINK_HALF - 1))
    begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= ~blink_reg;
    end
    else
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
  end
  always_ff @(posedge clk_in or negedge rstn)
  begin
    if (!rstn)
      stat_out <= 1'b1;
    else if (thermistor_fault_in || safety_timer_fault_in)
      stat_out <= blink_reg;
    else
      stat_out <= !(phase_reg == chgctl_pkg::PH_PRE || phase_reg == chgctl_pkg::PH_FAST);
  end
  always_ff @(posedge clk_in or negedge rstn)
  begin
    if (!rstn)
      int_cnt_reg <= 3'h0;
    else if (pgood_ev || bfault_ev || done_ev)
      int_cnt_reg <= 3'(chgctl_pkg::INT_PULSE_CYC);
    else if (int_cnt_reg != 3'h0)
      int_cnt_reg <= int_cnt_reg - 3'h1;
  end
  assign int_out = (int_cnt_reg != 3'h0);
endmodule : chgctl_top

// [sim/chgctl_props.sv]
// chgctl_props: concurrent checks on the charger control ports
`timescale 1ns/1ps
module chgctl_props #(
  parameter int BOOST_DLY = 20
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // conditions
  input wire logic src_ok_in,
  input wire logic detect_done_in,
  input wire logic sys_above_2v2_in,
  input wire logic light_load_in,
  input wire logic bat_below_minsys_in,
  input wire logic bat_above_lowbat_in,
  input wire logic vbus_below_sleep_in,
  input wire logic on_the_go_pin_in,
  input wire logic charge_en_n_in,
  input wire logic thermistor_fault_in,
  input wire logic safety_timer_fault_in,
  input wire logic boost_fault_in,
  input wire logic input_current_over_in,
  input wire logic input_voltage_under_in,
  // observed outputs
  input wire logic high_side_switch_en_out,
  input wire logic pfm_mode_out,
  input wire logic boost_mode_out,
  input wire logic [2:0] input_limit_out,
  input wire logic minsys_reg_out,
  input wire logic reduce_charge_out,
  input wire logic run_detect_out,
  input wire logic stat_out,
  input wire logic int_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  // ==========================================================
  // boost qualifier run length
  int boost_q_cnt_reg;
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      boost_q_cnt_reg <= 0;
    else if (on_the_go_pin_in && bat_above_lowbat_in && vbus_below_sleep_in)
      boost_q_cnt_reg <= boost_q_cnt_reg + 1;
    else
      boost_q_cnt_reg <= 0;
  end
  // ==========================================================
  // assertions
  a_int_pulse: assert property (
    $rose(int_out) |-> int_out [*4])
    else $error("int pulse short");
  a_limit_soft: assert property (
    !sys_above_2v2_in [*2] |-> input_limit_out == chgctl_pkg::EXTERNAL_LIMIT_PIN_100MA)
    else $error("limit not forced");
  a_pfm_light: assert property (
    (light_load_in && (bat_below_minsys_in || charge_en_n_in) && high_side_switch_en_out
      && !boost_mode_out) [*3] |-> pfm_mode_out)
    else $error("pfm missing");
  a_minsys_reg: assert property (
    (bat_below_minsys_in && high_side_switch_en_out && !boost_mode_out) [*3] |-> minsys_reg_out)
    else $error("minreg missing");
  a_reduce_cause: assert property (
    reduce_charge_out |-> input_current_over_in || input_voltage_under_in)
    else $error("reduce no cause");
  a_detect_clear: assert property (
    run_detect_out && detect_done_in |=> !run_detect_out && high_side_switch_en_out)
    else $error("detect end wrong");
  a_boost_delay: assert property (
    $rose(boost_mode_out) |-> boost_q_cnt_reg >= BOOST_DLY - 1)
    else $error("boost early");
  a_pgood_int: assert property (
    $rose(src_ok_in) |-> ##[1:6] int_out)
    else $error("no pgood int");
  a_bfault_int: assert property (
    $rose(boost_fault_in) && boost_mode_out |-> ##[1:6] int_out)
    else $error("no fault int");
  a_stat_idle: assert property (
    (charge_en_n_in && !thermistor_fault_in && !safety_timer_fault_in) [*4] |-> stat_out)
    else $error("stat low disabled");
  c_boost: cover property ($rose(boost_mode_out));
  c_stat_rise: cover property ($rose(stat_out));
  c_detect_end: cover property ($fell(run_detect_out));
endmodule : chgctl_props
bind chgctl_top chgctl_props #(.BOOST_DLY(BOOST_DLY)) chgctl_props_i (.clk_in, .rstn_in,
  .src_ok_in, .detect_done_in, .sys_above_2v2_in, .light_load_in, .bat_below_minsys_in,
  .bat_above_lowbat_in, .vbus_below_sleep_in, .on_the_go_pin_in, .charge_en_n_in,
  .thermistor_fault_in, .safety_timer_fault_in, .boost_fault_in, .input_current_over_in,
  .input_voltage_under_in, .high_side_switch_en_out, .pfm_mode_out, .boost_mode_out,
  .input_limit_out, .minsys_reg_out, .reduce_charge_out, .run_detect_out, .stat_out, .int_out);

// [sim/chgctl_far_model.sv]
// chgctl_far_model: source side detection answer
`timescale 1ns/1ps
module chgctl_far_model #(
  parameter int DET_CYC = 5
) (
  // clock
  input wire logic clk_in,
  // detection handshake
  input wire logic run_detect_in,
  output logic detect_done_out,
  output logic [1:0] detect_src_out,
  output logic [2:0] detect_lim_out
);
  int cnt = 0;
  always @(posedge clk_in)
    cnt <= run_detect_in ? cnt + 1 : 0;
  // released lines show another code
  assign detect_done_out = run_detect_in && (cnt >= DET_CYC);
  assign detect_src_out = run_detect_in ? 2'h1 : 2'h2;
  assign detect_lim_out = run_detect_in ? 3'h4 : 3'h3;
endmodule : chgctl_far_model

// [sim/chgctl_top_tb.sv]
// chgctl_top_tb: directed bench
`timescale 1ns/1ps
module chgctl_top_tb;
  // ==========================================================
  // stimulus and observed signals
  logic clk_in = 1'b0, rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00, rdata_out, s;
  logic [2:0] external_limit_pin_in = 3'h0, detect_lim_in, input_limit_out;
  logic [1:0] detect_src_in;
  logic src_ok_in = 1'b0, sys_above_2v2_in = 1'b1, light_load_in = 1'b0;
  logic bat_below_minsys_in = 1'b0, bat_above_lowbat_in = 1'b1, vbus_below_sleep_in = 1'b0;
  logic on_the_go_pin_in = 1'b0, charge_en_n_in = 1'b0, thermistor_fault_in = 1'b0;
  logic safety_timer_fault_in = 1'b0, boost_fault_in = 1'b0, input_current_over_in = 1'b0;
  logic input_voltage_under_in = 1'b0, sys_below_bat_in = 1'b0, bat_depleted_in = 1'b0;
  logic bat_above_precharge_in = 1'b0, chg_below_term_in = 1'b0, bat_above_recharge_in = 1'b0;
  logic detect_done_in, high_side_switch_en_out, low_side_switch_en_out, battery_switch_on_out;
  logic battery_switch_linear_out, pfm_mode_out, boost_mode_out, boost_high_current_out;
  logic minsys_reg_out, reduce_charge_out, run_detect_out, stat_out, int_out, int_q = 1'b0;
  int n_fail = 0, n_compared = 0, n_int = 0, hi, lo;
  logic [3:0] ra [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h6, 4'hf};
  logic [7:0] rv [9] = '{8'h30, 8'h1b, 8'h60, 8'h11, 8'hb2, 8'h9a, 8'h4b, 8'h00, 8'h00};
  chgctl_top #(.BOOST_DLY(20), .BLINK_HALF(8)) chgctl_top_i (.clk_in, .rstn_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .src_ok_in, .detect_done_in, .detect_src_in,
    .detect_lim_in, .external_limit_pin_in, .sys_above_2v2_in, .light_load_in,
    .bat_below_minsys_in, .bat_above_lowbat_in, .vbus_below_sleep_in, .on_the_go_pin_in,
    .charge_en_n_in, .thermistor_fault_in, .safety_timer_fault_in, .boost_fault_in,
    .input_current_over_in, .input_voltage_under_in, .sys_below_bat_in, .bat_depleted_in,
    .bat_above_precharge_in, .chg_below_term_in, .bat_above_recharge_in,
    .high_side_switch_en_out, .low_side_switch_en_out, .battery_switch_on_out,
    .battery_switch_linear_out, .pfm_mode_out, .boost_mode_out, .boost_high_current_out,
    .input_limit_out, .minsys_reg_out, .reduce_charge_out, .run_detect_out, .stat_out, .int_out);
  chgctl_far_model chgctl_far_model_i (.clk_in, .run_detect_in(run_detect_out),
    .detect_done_out(detect_done_in), .detect_src_out(detect_src_in),
    .detect_lim_out(detect_lim_in));
  always #5 clk_in = ~clk_in;
  // counts interrupt pulses
  always @(posedge clk_in)
  begin
    int_q <= int_out;
    if (int_out && !int_q)
      n_int <= n_int + 1;
  end
  // ==========================================================
  // access and compare tasks
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc
  task automatic pk(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : pk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    s = rdata_out;
  endtask : rd
  task automatic ph(input logic [1:0] e);
    rd(chgctl_pkg::ADDR_STATUS);
    chk("phase", 8'(s[5:4]), 8'(e));
  endtask : ph
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  // ==========================================================
  // directed sequence
  initial
  begin
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    pk(3);
    chk("stat reset", 8'(stat_out), 8'h01);
    foreach (ra[i])
    begin
      rd(ra[i]);
      chk("reset value", s, rv[i]);
    end
    wr(4'h6, 8'h5a);
    wr(chgctl_pkg::ADDR_STATUS, 8'hff);
    rd(4'h6);
    chk("unmapped", s, 8'h00);
    rd(chgctl_pkg::ADDR_STATUS);
    chk("status ro", s, 8'h00);
    cyc(1);
    src_ok_in <= 1'b1;
    pk(30);
    chk("int count", 8'(n_int), 8'h01);
    chk("switches", 8'({high_side_switch_en_out, low_side_switch_en_out}), 8'h03);
    chk("bat switch", 8'(battery_switch_on_out), 8'h01);
    chk("stat chg", 8'(stat_out), 8'h00);
    ph(chgctl_pkg::PH_PRE);
    chk("power good", 8'(s[2]), 8'h01);
    cyc(1);
    bat_above_precharge_in <= 1'b1;
    input_current_over_in <= 1'b1;
    chg_below_term_in <= 1'b1;
    bat_above_recharge_in <= 1'b1;
    pk(4);
    chk("reduce", 8'(reduce_charge_out), 8'h01);
    ph(chgctl_pkg::PH_FAST);
    chk("pm bit", 8'(s[3]), 8'h01);
    cyc(1);
    input_current_over_in <= 1'b0;
    input_voltage_under_in <= 1'b1;
    pk(4);
    ph(chgctl_pkg::PH_FAST);
    chk("pm bit", 8'(s[3]), 8'h01);
    cyc(1);
    input_voltage_under_in <= 1'b0;
    pk(4);
    ph(chgctl_pkg::PH_DONE);
    chk("pm clear", 8'(s[3]), 8'h00);
    chk("int count", 8'(n_int), 8'h02);
    chk("stat done", 8'(stat_out), 8'h01);
    cyc(1);
    sys_below_bat_in <= 1'b1;
    pk(3);
    chk("supplement", 8'(battery_switch_on_out), 8'h01);
    cyc(1);
    bat_depleted_in <= 1'b1;
    pk(3);
    chk("depleted", 8'(battery_switch_on_out), 8'h00);
    cyc(1);
    sys_below_bat_in <= 1'b0;
    bat_depleted_in <= 1'b0;
    bat_above_recharge_in <= 1'b0;
    pk(4);
    ph(chgctl_pkg::PH_FAST);
    wr(chgctl_pkg::ADDR_INLIM, 8'h35);
    chg_below_term_in <= 1'b0;
    external_limit_pin_in <= 3'h3;
    pk(3);
    chk("limit pin", 8'(input_limit_out), 8'h03);
    cyc(1);
    external_limit_pin_in <= 3'h7;
    pk(3);
    chk("limit reg", 8'(input_limit_out), 8'h05);
    cyc(1);
    sys_above_2v2_in <= 1'b0;
    light_load_in <= 1'b1;
    bat_below_minsys_in <= 1'b1;
    pk(3);
    chk("limit soft", 8'(input_limit_out), 8'h00);
    chk("pfm", 8'(pfm_mode_out), 8'h01);
    chk("linear", 8'(battery_switch_linear_out), 8'h01);
    rd(chgctl_pkg::ADDR_STATUS);
    chk("minreg bit", 8'(s[0]), 8'h01);
    cyc(1);
    sys_above_2v2_in <= 1'b1;
    bat_below_minsys_in <= 1'b0;
    charge_en_n_in <= 1'b1;
    pk(4);
    chk("pfm off chg", 8'(pfm_mode_out), 8'h01);
    chk("minreg dis", 8'(minsys_reg_out), 8'h01);
    chk("bat sw dis", 8'(battery_switch_on_out), 8'h00);
    chk("stat dis", 8'(stat_out), 8'h01);
    ph(chgctl_pkg::PH_OFF);
    cyc(1);
    charge_en_n_in <= 1'b0;
    light_load_in <= 1'b0;
    pk(4);
    chk("minreg off", 8'(minsys_reg_out), 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      cyc(1);
      thermistor_fault_in <= (k == 0);
      safety_timer_fault_in <= (k == 1);
      hi = 0;
      lo = 0;
      repeat (40) @(negedge clk_in) if (stat_out === 1'b1) hi++; else lo++;
      chk("blink", 8'({hi > 4, lo > 4}), 8'h03);
    end
    cyc(1);
    safety_timer_fault_in <= 1'b0;
    wr(chgctl_pkg::ADDR_MISC, 8'hcb);
    pk(1);
    chk("run detect", 8'(run_detect_out), 8'h01);
    rd(chgctl_pkg::ADDR_MISC);
    chk("force set", s, 8'hcb);
    pk(10);
    rd(chgctl_pkg::ADDR_MISC);
    chk("force clear", s, 8'h4b);
    chk("running", 8'(high_side_switch_en_out), 8'h01);
    cyc(1);
    src_ok_in <= 1'b0;
    vbus_below_sleep_in <= 1'b1;
    wr(chgctl_pkg::ADDR_CHGCFG, 8'h2b);
    on_the_go_pin_in <= 1'b1;
    cyc(10);
    on_the_go_pin_in <= 1'b0;
    cyc(1);
    on_the_go_pin_in <= 1'b1;
    pk(15);
    chk("boost early", 8'(boost_mode_out), 8'h00);
    pk(10);
    chk("boost on", 8'(boost_mode_out), 8'h01);
    chk("boost hi", 8'(boost_high_current_out), 8'h01);
    rd(chgctl_pkg::ADDR_STATUS);
    chk("source", 8'(s[7:6]), 8'(chgctl_pkg::SRC_BOOST));
    wr(chgctl_pkg::ADDR_CHGCFG, 8'h2a);
    boost_fault_in <= 1'b1;
    pk(6);
    chk("boost lo", 8'(boost_high_current_out), 8'h00);
    chk("int count", 8'(n_int), 8'h03);
    cyc(1);
    boost_fault_in <= 1'b0;
    rd(chgctl_pkg::ADDR_FAULT);
    chk("fault set", 8'(s[6]), 8'h01);
    rd(chgctl_pkg::ADDR_FAULT);
    chk("fault read", 8'(s[6]), 8'h00);
    print_verdict();
  end
  initial
  begin
    repeat (5000) @(posedge clk_in);
    n_fail++;
    print_verdict();
  end
endmodule : chgctl_top_tb
